// ==== rtl/uart_intr_pkg.sv ====
// Constants for the UART interrupt identification and FIFO control block
package uart_intr_pkg;
    // Byte offsets of the register words
    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_IER = 6'h04;
    localparam logic [5:0] OFS_IDENT = 6'h08;
    localparam logic [5:0] OFS_LSTATE = 6'h14;
    localparam logic [5:0] OFS_PWREMU = 6'h30;
    // fifo_control fields
    localparam int FC_TRIG_HI = 7;
    localparam int FC_TRIG_LO = 6;
    localparam int FC_DMA = 3;
    localparam int FC_TRANSMIT_FIFO_CLEAR = 2;
    localparam int FC_RECEIVE_FIFO_CLEAR = 1;
    localparam int FC_EN = 0;
    // Interrupt enable fields
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LS = 2;
    // line_state_reg fields
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_THRE = 5;
    localparam int LS_TEMT = 6;
    localparam int LS_ERR = 7;
    // power_emulation_control field: receiver_reset_control, 1 = receiver running
    localparam int PW_RX_RUN = 0;
    // interrupt_type_code values
    localparam logic [2:0] TYPE_NONE = 3'h0;
    localparam logic [2:0] TYPE_THRE = 3'h1;
    localparam logic [2:0] TYPE_RDA = 3'h2;
    localparam logic [2:0] TYPE_LS = 3'h3;
    localparam logic [2:0] TYPE_TO = 3'h6;
    localparam logic [1:0] FIFO_STATE_ON = 2'h3;
    localparam logic [1:0] FIFO_STATE_OFF = 2'h0;
    // Trigger levels in bytes
    localparam logic [4:0] TRIG_0 = 5'h01;
    localparam logic [4:0] TRIG_1 = 5'h04;
    localparam logic [4:0] TRIG_2 = 5'h08;
    localparam logic [4:0] TRIG_3 = 5'h0E;
    // FIFO geometry and timing
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] HOLD_DEPTH = 5'h01;
    localparam logic [2:0] CHAR_TIMEOUT = 3'h4;
    // Reset values
    localparam logic [1:0] TRIG_RST = 2'h0;
    localparam logic [2:0] IER_RST = 3'h0;
    localparam logic PW_RST = 1'b0;
endpackage

// ==== rtl/uart_interrupt_fifo_control.sv ====
// UART interrupt identification, FIFO control and FIFO counters over Avalon-MM
//
// Chosen here: the address map and the Avalon-MM slave port.
module uart_interrupt_fifo_control import uart_intr_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_err,
    input wire logic char_time_tick,
    input wire logic dma_rx_read,
    output logic [7:0] rx_head_data,
    input wire logic tx_take,
    output logic [7:0] tx_data,
    output logic tx_avail,
    output logic intr_req,
    output logic dma_mode,
    output logic fifo_mode
);
    function automatic logic [4:0] trig_level(input logic [1:0] code);
        unique case (code)
            2'h0: trig_level = TRIG_0;
            2'h1: trig_level = TRIG_1;
            2'h2: trig_level = TRIG_2;
            2'h3: trig_level = TRIG_3;
        endcase
    endfunction

    logic ack_r;
    logic [31:0] readdata_r;
    logic fifo_en_r;
    logic [1:0] trig_r;
    logic dma_r;
    logic [2:0] ier_r;
    logic rx_run_r;
    logic [8:0] rx_mem [0:15];
    logic [7:0] tx_mem [0:15];
    logic [3:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic [4:0] rx_cnt_r, tx_cnt_r, err_cnt_r;
    logic [2:0] idle_r;
    logic to_r, ovr_r, thre_r;
    logic [31:0] lsr_val;
    logic [31:0] rd_mux;

    // Bus decode; one wait state per access
    wire logic [5:0] word_addr = {avs_address[5:2], 2'b00};
    wire logic sel_data = word_addr == OFS_DATA;
    wire logic sel_ier = word_addr == OFS_IER;
    wire logic sel_ident = word_addr == OFS_IDENT;
    wire logic sel_lstate = word_addr == OFS_LSTATE;
    wire logic sel_pwr = word_addr == OFS_PWREMU;
    wire logic req = avs_read | avs_write;
    wire logic acc_rd = avs_read & ack_r;
    wire logic acc_wr = avs_write & ack_r;
    wire logic wr_thr = acc_wr & sel_data;
    wire logic rd_rbr = acc_rd & sel_data;
    wire logic wr_ier = acc_wr & sel_ier;
    wire logic wr_fcr = acc_wr & sel_ident;
    wire logic rd_lsr = acc_rd & sel_lstate;
    wire logic wr_pwr = acc_wr & sel_pwr;
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = readdata_r;

    // FIFO control write decode
    wire logic fcr_prog = wr_fcr & fifo_en_r;
    wire logic fifo_en_nxt = wr_fcr ? avs_writedata[FC_EN] : fifo_en_r;
    wire logic mode_change = fifo_en_nxt != fifo_en_r;
    wire logic rx_clr = (fcr_prog & avs_writedata[FC_RECEIVE_FIFO_CLEAR]) | mode_change;
    wire logic tx_clr = (fcr_prog & avs_writedata[FC_TRANSMIT_FIFO_CLEAR]) | mode_change;
    wire logic [1:0] trig_nxt = fcr_prog ? avs_writedata[FC_TRIG_HI:FC_TRIG_LO] : trig_r;
    wire logic dma_nxt = fcr_prog ? avs_writedata[FC_DMA] : dma_r;
    wire logic [4:0] depth = fifo_en_r ? FIFO_DEPTH : HOLD_DEPTH;
    wire logic rx_rst_load = wr_pwr & ~avs_writedata[PW_RX_RUN];

    // Receive FIFO
    wire logic [8:0] rx_head = rx_mem[rx_rp_r];
    wire logic rx_has = rx_cnt_r != 5'h00;
    wire logic rx_in = rx_char_valid & rx_run_r;
    wire logic rx_push = rx_in & (rx_cnt_r < depth) & ~rx_clr;
    wire logic ovr_evt = rx_in & (rx_cnt_r >= depth);
    wire logic rx_pop = (rd_rbr | dma_rx_read) & rx_has & ~rx_clr;
    wire logic push_err = rx_push & rx_char_err;
    wire logic pop_err = rx_pop & rx_head[8];
    wire logic [4:0] rx_cnt_nxt = rx_clr ? 5'h00 :
        rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
    wire logic [4:0] err_cnt_nxt = rx_clr ? 5'h00 :
        err_cnt_r + {4'h0, push_err} - {4'h0, pop_err};
    assign rx_head_data = rx_head[7:0];

    // Character time-out tracking
    wire logic rx_touch = rx_push | rx_pop | rx_clr | rx_rst_load;
    wire logic idle_step = char_time_tick & rx_has & (idle_r != CHAR_TIMEOUT);
    wire logic [2:0] idle_nxt = rx_touch ? 3'h0 : (idle_step ? idle_r + 3'h1 : idle_r);
    wire logic to_set = fifo_en_r & ~rx_touch & char_time_tick & rx_has &
        (idle_r == CHAR_TIMEOUT - 3'h1);
    wire logic to_clr = rx_pop | rx_push | rx_rst_load | rx_clr;
    wire logic to_nxt = to_set | (to_r & ~to_clr);

    // Overrun flag, set wins over line status read
    wire logic ovr_nxt = ovr_evt | (ovr_r & ~rd_lsr);

    // Transmit FIFO
    wire logic tx_push = wr_thr & (tx_cnt_r < depth) & ~tx_clr;
    wire logic tx_pop = tx_take & (tx_cnt_r != 5'h00) & ~tx_clr;
    wire logic [4:0] tx_cnt_nxt = tx_clr ? 5'h00 :
        tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
    wire logic thre_set = ((tx_cnt_r != 5'h00) & (tx_cnt_nxt == 5'h00)) | tx_clr;
    wire logic thre_nxt = thre_set | (thre_r & ~wr_thr);
    assign tx_data = tx_mem[tx_rp_r];
    assign tx_avail = tx_cnt_r != 5'h00;

    // Interrupt sources, gating and priority
    wire logic ls_src = ovr_r | (err_cnt_r != 5'h00);
    wire logic rda_src = fifo_en_r ? (rx_cnt_r >= trig_level(trig_r)) : rx_has;
    wire logic ls_act = ls_src & ier_r[IE_LS];
    wire logic rda_act = rda_src & ier_r[IE_RX];
    wire logic to_act = to_r & ier_r[IE_RX];
    wire logic thre_act = thre_r & ier_r[IE_TX];
    wire logic any_act = ls_act | rda_act | to_act | thre_act;
    wire logic [2:0] int_type = ls_act ? TYPE_LS :
        rda_act ? TYPE_RDA :
        to_act ? TYPE_TO :
        thre_act ? TYPE_THRE : TYPE_NONE;
    wire logic interrupt_pending_n = ~any_act;
    wire logic [1:0] fifo_state = fifo_en_r ? FIFO_STATE_ON : FIFO_STATE_OFF;
    wire logic [31:0] interrupt_ident_reg = {24'h0, fifo_state, 2'b00, int_type,
        interrupt_pending_n};
    assign intr_req = any_act;
    assign dma_mode = dma_r;
    assign fifo_mode = fifo_en_r;

    always_comb begin
        lsr_val = 32'h0;
        lsr_val[LS_DR] = rx_has;
        lsr_val[LS_OE] = ovr_r;
        lsr_val[LS_THRE] = thre_r;
        lsr_val[LS_TEMT] = tx_cnt_r == 5'h00;
        lsr_val[LS_ERR] = err_cnt_r != 5'h00;
    end

    // Read mux; identification always answers the shared address
    always_comb begin
        rd_mux = 32'h0;
        if (sel_data) begin
            rd_mux = {24'h0, rx_has ? rx_head[7:0] : 8'h00};
        end else if (sel_ier) begin
            rd_mux = {29'h0, ier_r};
        end else if (sel_ident) begin
            rd_mux = interrupt_ident_reg;
        end else if (sel_lstate) begin
            rd_mux = lsr_val;
        end else if (sel_pwr) begin
            rd_mux = {31'h0, rx_run_r};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            readdata_r <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            readdata_r <= (avs_read & ~ack_r) ? rd_mux : readdata_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            fifo_en_r <= 1'b0;
            trig_r <= TRIG_RST;
            dma_r <= 1'b0;
            ier_r <= IER_RST;
            rx_run_r <= PW_RST;
        end else begin
            fifo_en_r <= fifo_en_nxt;
            trig_r <= trig_nxt;
            dma_r <= dma_nxt;
            ier_r <= wr_ier ? avs_writedata[2:0] : ier_r;
            rx_run_r <= wr_pwr ? avs_writedata[PW_RX_RUN] : rx_run_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_wp_r <= 4'h0;
            rx_rp_r <= 4'h0;
            rx_cnt_r <= 5'h00;
            err_cnt_r <= 5'h00;
            idle_r <= 3'h0;
            to_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            rx_wp_r <= rx_clr ? 4'h0 : rx_wp_r + {3'h0, rx_push};
            rx_rp_r <= rx_clr ? 4'h0 : rx_rp_r + {3'h0, rx_pop};
            rx_cnt_r <= rx_cnt_nxt;
            err_cnt_r <= err_cnt_nxt;
            idle_r <= idle_nxt;
            to_r <= to_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_wp_r <= 4'h0;
            tx_rp_r <= 4'h0;
            tx_cnt_r <= 5'h00;
            thre_r <= 1'b1;
        end else begin
            tx_wp_r <= tx_clr ? 4'h0 : tx_wp_r + {3'h0, tx_push};
            tx_rp_r <= tx_clr ? 4'h0 : tx_rp_r + {3'h0, tx_pop};
            tx_cnt_r <= tx_cnt_nxt;
            thre_r <= thre_nxt;
        end
    end

    // Data arrays carry no reset
    always_ff @(posedge ref_clk) begin
        if (rx_push) begin
            rx_mem[rx_wp_r] <= {rx_char_err, rx_char_data};
        end
        if (tx_push) begin
            tx_mem[tx_wp_r] <= avs_writedata[7:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_req_start;
        req && !ack_r;
    endsequence
    sequence s_answer;
        ##1 !avs_waitrequest;
    endsequence
    sequence s_idle_last;
        fifo_en_r && !rx_touch && char_time_tick && rx_has && idle_r == 3'h3;
    endsequence

    a_bus_answer: assert property (s_req_start |-> s_answer)
        else $error("bus request not answered after one wait state");
    a_ident_none: assert property (!any_act |-> interrupt_ident_reg[3:0] == 4'h1)
        else $error("idle ident code wrong");
    a_line_first: assert property (ls_act |-> interrupt_ident_reg[3:0] == 4'h6)
        else $error("line status not reported first");
    a_ovr_clear: assert property (rd_lsr && !ovr_evt |=> !ovr_r)
        else $error("overrun not cleared by line status read");
    a_err_hold: assert property (err_cnt_r != 5'h00 && ier_r[IE_LS]
        |-> interrupt_ident_reg[3:1] == TYPE_LS)
        else $error("error bytes left but line status gone");
    a_rx_timeout: assert property (s_idle_last ##1 ier_r[IE_RX] && !ls_act && !rda_act
        |-> interrupt_ident_reg[3:0] == 4'hC)
        else $error("time-out not raised after four character times");
    a_to_clear: assert property (to_r && (rx_pop || rx_push || rx_rst_load) |=> !to_r)
        else $error("time-out not cleared");
    a_rda_level: assert property (fifo_en_r && ier_r[IE_RX] && !ls_act &&
        rx_cnt_r >= trig_level(trig_r) |-> interrupt_ident_reg[3:0] == 4'h4)
        else $error("data ready missing at trigger level");
    a_rda_drop: assert property (fifo_en_r && rx_cnt_r < trig_level(trig_r) |-> !rda_src)
        else $error("data ready held below trigger");
    a_thre_clear: assert property (wr_thr && !thre_set |=> !thre_r)
        else $error("transmit empty not cleared by write");
    a_fcr_ignore: assert property (wr_fcr && !fifo_en_r
        |=> trig_r == $past(trig_r) && dma_r == $past(dma_r))
        else $error("fifo control field written while disabled");
    a_rx_clear: assert property (fcr_prog && avs_writedata[FC_RECEIVE_FIFO_CLEAR]
        |=> rx_cnt_r == 5'h00 && err_cnt_r == 5'h00)
        else $error("receive clear left data");
    a_fifo_state: assert property (interrupt_ident_reg[7:6] == (fifo_en_r ? 2'h3 : 2'h0))
        else $error("fifo state field wrong");
    a_pend_gate: assert property (ier_r == 3'h0 |-> interrupt_ident_reg[0])
        else $error("pending shown with all sources disabled");
endmodule // uart_interrupt_fifo_control

// ==== verification/uart_far_side_model.sv ====
// Far side model: receive shifter, character timer, transmit shifter, DMA reader
module uart_far_side_model (
    input wire logic ref_clk,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_char_err,
    output logic char_time_tick,
    output logic dma_rx_read,
    output logic tx_take
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_char_valid = 1'h0;
        rx_char_data = 8'h5A;
        rx_char_err = 1'h0;
        char_time_tick = 1'h0;
        dma_rx_read = 1'h0;
        tx_take = 1'h0;
    end
    task automatic send_char(input logic [7:0] d, input logic e);
        @(posedge ref_clk);
        rx_char_valid <= 1'h1;
        rx_char_data <= d;
        rx_char_err <= e;
        @(posedge ref_clk);
        rx_char_valid <= 1'h0;
        // Released lines carry no stale value
        rx_char_data <= ~d;
        rx_char_err <= ~e;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            char_time_tick <= 1'h1;
            @(posedge ref_clk);
            char_time_tick <= 1'h0;
        end
    endtask
    task automatic dma_pop();
        @(posedge ref_clk);
        dma_rx_read <= 1'h1;
        @(posedge ref_clk);
        dma_rx_read <= 1'h0;
    endtask
    task automatic take_tx();
        @(posedge ref_clk);
        tx_take <= 1'h1;
        @(posedge ref_clk);
        tx_take <= 1'h0;
    endtask
endmodule // uart_far_side_model

// ==== verification/uart_interrupt_fifo_control_test.sv ====
// Self-checking bench for the UART interrupt and FIFO control block
module uart_interrupt_fifo_control_test import uart_intr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, rx_char_valid, rx_char_err, char_time_tick, dma_rx_read, tx_take;
    logic [7:0] rx_char_data, rx_head_data, tx_data, b;
    logic tx_avail, intr_req, dma_mode, fifo_mode;
    logic [7:0] q[$];
    int miscompares = 0;
    int check_count = 0;
    always #50 ref_clk = ~ref_clk;
    uart_interrupt_fifo_control dut_u (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_char_valid, .rx_char_data,
        .rx_char_err, .char_time_tick, .dma_rx_read, .rx_head_data, .tx_take, .tx_data,
        .tx_avail, .intr_req, .dma_mode, .fifo_mode);
    uart_far_side_model far_u (.ref_clk, .rx_char_valid, .rx_char_data, .rx_char_err,
        .char_time_tick, .dma_rx_read, .tx_take);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'h0) begin
                rd = avs_readdata;
                break;
            end
            if (i == 19) begin
                miscompares++;
                end_of_test();
            end
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        // Let the accepted access settle before callers compare outputs
        @(negedge ref_clk);
    endtask
    task automatic ident(input logic [7:0] e);
        bus(1'h0, OFS_IDENT, 32'h0);
        check(rd, {24'h0, e}, "ident");
    endtask
    task automatic push(input logic e);
        b = 8'($urandom);
        q.push_back(b);
        far_u.send_char(b, e);
    endtask
    task automatic pop_check();
        bus(1'h0, OFS_DATA, 32'h0);
        check(rd, {24'h0, q.pop_front()}, "rx data");
    endtask
    function automatic int trig_bytes(input logic [1:0] t);
        return (t == 2'h0) ? 1 : (t == 2'h1) ? 4 : (t == 2'h2) ? 8 : 14;
    endfunction
    initial begin
        void'($urandom(65211));
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        ident(8'h01);
        bus(1'h1, OFS_IDENT, 32'h08);
        check(dma_mode, 1'h0, "dma before enable");
        bus(1'h1, OFS_IDENT, 32'h01);
        bus(1'h1, OFS_IDENT, 32'h09);
        check({fifo_mode, dma_mode}, 2'h3, "mode bits");
        bus(1'h1, OFS_PWREMU, 32'h1);
        bus(1'h0, 6'h3C, 32'h0);
        check(rd, 32'h0, "unmapped");
        $display("test setup done");
        bus(1'h1, OFS_IER, 32'h1);
        for (logic [2:0] t = 3'h0; t < 3'h4; t++) begin
            bus(1'h1, OFS_IDENT, {24'h0, t[1:0], 6'h0B});
            q.delete();
            bus(1'h0, OFS_LSTATE, 32'h0);
            check(rd[LS_DR], 1'h0, "rx cleared");
            repeat (trig_bytes(t[1:0]) - 1) push(1'h0);
            ident(8'hC1);
            push(1'h0);
            ident(8'hC4);
            bus(1'h1, OFS_IDENT, {24'h0, t[1:0], 6'h09});
            ident(8'hC4);
            pop_check();
            ident(8'hC1);
        end
        $display("test trigger done");
        bus(1'h1, OFS_IDENT, 32'hCB);
        q.delete();
        push(1'h0);
        far_u.tick(3);
        ident(8'hC1);
        far_u.tick(1);
        ident(8'hCC);
        push(1'h0);
        ident(8'hC1);
        far_u.tick(4);
        ident(8'hCC);
        check(rx_head_data, q.pop_front(), "dma head");
        far_u.dma_pop();
        ident(8'hC1);
        far_u.tick(4);
        bus(1'h1, OFS_IER, 32'h0);
        ident(8'hC1);
        check(intr_req, 1'h0, "irq gated");
        bus(1'h1, OFS_IER, 32'h1);
        ident(8'hCC);
        check(intr_req, 1'h1, "irq pending");
        bus(1'h1, OFS_PWREMU, 32'h0);
        ident(8'hC1);
        bus(1'h1, OFS_PWREMU, 32'h1);
        $display("test timeout done");
        bus(1'h1, OFS_IDENT, 32'hCB);
        q.delete();
        bus(1'h1, OFS_IER, 32'h7);
        ident(8'hC2);
        push(1'h1);
        ident(8'hC6);
        pop_check();
        ident(8'hC2);
        b = 8'($urandom);
        bus(1'h1, OFS_DATA, {24'h0, b});
        ident(8'hC1);
        check({tx_avail, tx_data}, {1'h1, b}, "tx head");
        far_u.take_tx();
        ident(8'hC2);
        $display("test status done");
        bus(1'h1, OFS_IDENT, 32'h08);
        check(fifo_mode, 1'h0, "fifo off");
        bus(1'h1, OFS_IER, 32'h1);
        push(1'h0);
        ident(8'h04);
        push(1'h0);
        bus(1'h1, OFS_IER, 32'h5);
        ident(8'h06);
        bus(1'h0, OFS_LSTATE, 32'h0);
        check(rd[LS_OE], 1'h1, "overrun");
        ident(8'h04);
        pop_check();
        ident(8'h01);
        bus(1'h1, OFS_IDENT, 32'hC8);
        ident(8'h01);
        $display("test non-fifo done");
        end_of_test();
    end
endmodule // uart_interrupt_fifo_control_test
